// ==== src/csp_pkg.sv ====
// Shared widths, depths and beat layouts for the chip-to-chip stream port
package csp_pkg;

	localparam int BYTE_W     = 8;
	localparam int LANES      = 8;
	localparam int DATA_W     = BYTE_W * LANES;
	localparam int ID_W       = 8;
	localparam int DEST_W     = 8;
	localparam int ROUTE_W    = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W      = 4;

	// Outgoing destination is never anything but zero
	localparam logic [DEST_W-1:0] TX_DEST_VALUE = 8'h00;
	// Receive ready drops while this many slots or fewer are left
	localparam int RX_HEADROOM = 2;

	// Beat offered by the mesh side for transmission
	typedef struct packed {
		logic [ID_W-1:0]   flow_id;
		logic [DATA_W-1:0] payload;
		logic [LANES-1:0]  byte_strobe;
		logic [LANES-1:0]  byte_keep;
		logic              packet_end;
	} csp_tx_beat_t;

	// Beat as taken from the link, held in the receive FIFO
	typedef struct packed {
		logic [DEST_W-1:0]  route_dest;
		logic [ID_W-1:0]    flow_id;
		logic [ROUTE_W-1:0] remote_agent_route;
		logic [DATA_W-1:0]  payload;
		logic [LANES-1:0]   byte_strobe;
		logic [LANES-1:0]   byte_keep;
		logic               packet_end;
	} csp_rx_beat_t;

	// Received beat with null bytes squeezed out, kept bytes packed low
	typedef struct packed {
		logic [DEST_W-1:0]  route_dest;
		logic [ID_W-1:0]    flow_id;
		logic [ROUTE_W-1:0] remote_agent_route;
		logic [DATA_W-1:0]  payload;
		logic [LANES-1:0]   byte_strobe;
		logic [CNT_W-1:0]   byte_count;
		logic               packet_end;
	} csp_rx_out_t;

endpackage : csp_pkg

// ==== src/csp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module csp_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16,
	parameter int LVL_W = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             SYS_RST,
	// Fill side
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data,
	// Occupancy
	output      logic [LVL_W-1:0] level
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);
	localparam logic [LVL_W-1:0] FULL_LVL  = LVL_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic             push;
	logic             pop;

	// Full and empty come straight from the level count
	assign in_ready  = (level != FULL_LVL);
	assign out_valid = (level != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage has no reset, only pointers and level do
	always_ff @(posedge CLOCK) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end

endmodule : csp_fifo

// ==== src/csp_stream_port.sv ====
// Chip-to-chip stream port: transmit master and receive slave with null-byte removal
`timescale 1ns/1ps
module csp_stream_port #(
	parameter int RX_FIFO_DEPTH = csp_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                                CLOCK,
	input  wire logic                                SYS_RST,
	// Mesh side, beats to send
	input  wire logic                                TX_USR_VALID,
	output      logic                                TX_USR_READY,
	input  wire csp_pkg::csp_tx_beat_t               TX_USR_BEAT,
	// Link transmit, stream master
	input  wire logic                                TX_BEAT_ACCEPT,
	output      logic                                TX_BEAT_VALID,
	output      logic [csp_pkg::DEST_W-1:0]          TX_ROUTE_DEST,
	output      logic [csp_pkg::ID_W-1:0]            TX_FLOW_ID,
	output      logic [csp_pkg::DATA_W-1:0]          TX_PAYLOAD,
	output      logic [csp_pkg::LANES-1:0]           TX_BYTE_STROBE,
	output      logic [csp_pkg::LANES-1:0]           TX_BYTE_KEEP,
	output      logic                                TX_PACKET_END,
	// Link receive, stream slave
	output      logic                                RX_BEAT_ACCEPT,
	input  wire logic                                RX_BEAT_VALID,
	input  wire logic [csp_pkg::DEST_W-1:0]          RX_ROUTE_DEST,
	input  wire logic [csp_pkg::ID_W-1:0]            RX_FLOW_ID,
	input  wire logic [csp_pkg::ROUTE_W-1:0]         RX_REMOTE_AGENT_ROUTE,
	input  wire logic [csp_pkg::DATA_W-1:0]          RX_PAYLOAD,
	input  wire logic [csp_pkg::LANES-1:0]           RX_BYTE_STROBE,
	input  wire logic [csp_pkg::LANES-1:0]           RX_BYTE_KEEP,
	input  wire logic                                RX_PACKET_END,
	// Mesh side, received beats after null-byte removal
	output      logic                                RX_USR_VALID,
	input  wire logic                                RX_USR_READY,
	output      csp_pkg::csp_rx_out_t                RX_USR_BEAT
);

	localparam int LVL_W = $clog2(RX_FIFO_DEPTH + 1);
	localparam logic [LVL_W-1:0] ACCEPT_LIMIT = LVL_W'(RX_FIFO_DEPTH - csp_pkg::RX_HEADROOM);

	// Count of set bits in a lane mask
	function automatic logic [csp_pkg::CNT_W-1:0] count_ones(input logic [csp_pkg::LANES-1:0] v);
		logic [csp_pkg::CNT_W-1:0] n;
		n = '0;
		for (int k = 0; k < csp_pkg::LANES; k++) begin
			n = n + {{(csp_pkg::CNT_W-1){1'b0}}, v[k]};
		end
		return n;
	endfunction : count_ones

	// ---------------- Transmit ----------------
	csp_pkg::csp_tx_beat_t tx_main;
	csp_pkg::csp_tx_beat_t tx_skid;
	logic                  tx_skid_valid;
	logic                  tx_take;
	logic                  usr_take;
	logic                  tx_slot_free;
	logic                  next_tx_valid;
	logic                  next_skid_valid;

	// Handshake decode; skid buffer keeps the user ready a flop
	assign tx_take         = TX_BEAT_VALID & TX_BEAT_ACCEPT;
	assign usr_take        = TX_USR_VALID & TX_USR_READY;
	assign tx_slot_free    = ~TX_BEAT_VALID | tx_take;
	assign next_tx_valid   = tx_slot_free ? (tx_skid_valid | usr_take) : 1'b1;
	assign next_skid_valid = tx_slot_free ? 1'b0 : (tx_skid_valid | usr_take);

	// Output register only reloads once the held beat has been taken
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			TX_BEAT_VALID <= 1'b0;
			tx_skid_valid <= 1'b0;
			TX_USR_READY  <= 1'b0;
			tx_main       <= '0;
			tx_skid       <= '0;
		end else begin
			TX_BEAT_VALID <= next_tx_valid;
			tx_skid_valid <= next_skid_valid;
			TX_USR_READY  <= ~next_skid_valid;
			if (tx_slot_free) begin
				tx_main <= tx_skid_valid ? tx_skid : TX_USR_BEAT;
			end
			if (!tx_slot_free && usr_take) begin
				tx_skid <= TX_USR_BEAT;
			end
		end
	end

	// Beat fields straight off the output register
	assign TX_FLOW_ID     = tx_main.flow_id;
	assign TX_PAYLOAD     = tx_main.payload;
	assign TX_BYTE_STROBE = tx_main.byte_strobe;
	assign TX_BYTE_KEEP   = tx_main.byte_keep;
	assign TX_PACKET_END  = tx_main.packet_end;

	// Destination flop never loads anything but the fixed value
	always_ff @(posedge CLOCK) begin
		TX_ROUTE_DEST <= csp_pkg::TX_DEST_VALUE;
	end

	// ---------------- Receive ----------------
	csp_pkg::csp_rx_beat_t rx_in;
	csp_pkg::csp_rx_beat_t rx_head;
	logic [$bits(csp_pkg::csp_rx_beat_t)-1:0] rx_head_bits;
	logic                  rx_push;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [LVL_W-1:0]      fifo_level;
	logic                  head_pop;
	logic                  head_keeps;
	logic                  head_deliver;
	logic [csp_pkg::CNT_W-1:0]  lane_pos [csp_pkg::LANES];
	logic [csp_pkg::DATA_W-1:0] packed_payload;
	logic [csp_pkg::LANES-1:0]  packed_strobe;

	// Gather link fields into one beat; tied-low idle link never pushes
	assign rx_in.route_dest         = RX_ROUTE_DEST;
	assign rx_in.flow_id            = RX_FLOW_ID;
	assign rx_in.remote_agent_route = RX_REMOTE_AGENT_ROUTE;
	assign rx_in.payload            = RX_PAYLOAD;
	assign rx_in.byte_strobe        = RX_BYTE_STROBE;
	assign rx_in.byte_keep          = RX_BYTE_KEEP;
	assign rx_in.packet_end         = RX_PACKET_END;
	assign rx_push                  = RX_BEAT_VALID & RX_BEAT_ACCEPT;

	csp_fifo #(
		.WIDTH ($bits(csp_pkg::csp_rx_beat_t)),
		.DEPTH (RX_FIFO_DEPTH),
		.LVL_W (LVL_W)
	) u_rx_fifo (
		.CLOCK     (CLOCK),
		.SYS_RST   (SYS_RST),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (rx_head_bits),
		.level     (fifo_level)
	);

	// Ready is a flop, so it looks one beat ahead: two slots of headroom
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			RX_BEAT_ACCEPT <= 1'b0;
		end else begin
			RX_BEAT_ACCEPT <= fifo_in_ready && (fifo_level < ACCEPT_LIMIT);
		end
	end

	// Position of each kept byte once nulls below it are squeezed out
	assign rx_head = rx_head_bits;
	generate
		for (genvar i = 0; i < csp_pkg::LANES; i++) begin : g_lane
			assign lane_pos[i] = count_ones(rx_head.byte_keep & ~(8'hff << i));
		end
	endgenerate

	// Pack kept bytes and their strobes into the low lanes
	always_comb begin
		packed_payload = '0;
		packed_strobe  = '0;
		for (int i = 0; i < csp_pkg::LANES; i++) begin
			if (rx_head.byte_keep[i]) begin
				packed_payload[{lane_pos[i][2:0], 3'h0} +: csp_pkg::BYTE_W] =
					rx_head.payload[i*csp_pkg::BYTE_W +: csp_pkg::BYTE_W];
				packed_strobe[lane_pos[i][2:0]] = rx_head.byte_strobe[i];
			end
		end
	end

	// All-null beats vanish unless they carry the packet end
	assign fifo_out_ready = ~RX_USR_VALID | RX_USR_READY;
	assign head_pop       = fifo_out_valid & fifo_out_ready;
	assign head_keeps     = (rx_head.byte_keep != '0);
	assign head_deliver   = head_pop & (head_keeps | rx_head.packet_end);

	// Output stage holds each beat until the mesh side takes it
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			RX_USR_VALID <= 1'b0;
			RX_USR_BEAT  <= '0;
		end else begin
			if (head_deliver) begin
				RX_USR_VALID                   <= 1'b1;
				RX_USR_BEAT.route_dest         <= rx_head.route_dest;
				RX_USR_BEAT.flow_id            <= rx_head.flow_id;
				RX_USR_BEAT.remote_agent_route <= rx_head.remote_agent_route;
				RX_USR_BEAT.payload            <= packed_payload;
				RX_USR_BEAT.byte_strobe        <= packed_strobe;
				RX_USR_BEAT.byte_count         <= count_ones(rx_head.byte_keep);
				RX_USR_BEAT.packet_end         <= rx_head.packet_end;
			end else if (RX_USR_READY) begin
				RX_USR_VALID <= 1'b0;
			end
		end
	end

endmodule : csp_stream_port

// ==== verif/csp_stream_port_properties.sv ====
// Concurrent checks on the stream port's top-level ports
`timescale 1ns/1ps
module csp_stream_port_properties (
	// Clock and reset
	input wire logic                 CLOCK,
	input wire logic                 SYS_RST,
	// Transmit side
	input wire logic                 TX_USR_VALID,
	input wire logic                 TX_USR_READY,
	input wire csp_pkg::csp_tx_beat_t TX_USR_BEAT,
	input wire logic                 TX_BEAT_ACCEPT,
	input wire logic                 TX_BEAT_VALID,
	input wire logic [7:0]           TX_ROUTE_DEST,
	input wire logic [7:0]           TX_FLOW_ID,
	input wire logic [63:0]          TX_PAYLOAD,
	input wire logic [7:0]           TX_BYTE_STROBE,
	input wire logic [7:0]           TX_BYTE_KEEP,
	input wire logic                 TX_PACKET_END,
	// Receive user side
	input wire logic                 RX_USR_VALID,
	input wire logic                 RX_USR_READY,
	input wire csp_pkg::csp_rx_out_t RX_USR_BEAT
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	// Offers left waiting on the far side
	sequence tx_stall;
		TX_BEAT_VALID && !TX_BEAT_ACCEPT;
	endsequence
	sequence rx_usr_stall;
		RX_USR_VALID && !RX_USR_READY;
	endsequence

	AST_TX_DEST: assert property (TX_BEAT_VALID |-> TX_ROUTE_DEST == 8'h00)
		else $error("outgoing destination not zero");
	AST_TX_HOLD: assert property (tx_stall |=> TX_BEAT_VALID && $stable({TX_FLOW_ID, TX_PAYLOAD,
		TX_BYTE_STROBE, TX_BYTE_KEEP, TX_PACKET_END})) else $error("transmit beat changed while stalled");
	AST_TX_ANSWER: assert property (TX_USR_VALID && TX_USR_READY |=> TX_BEAT_VALID)
		else $error("taken beat not offered");
	AST_TX_CAUSE: assert property (!TX_BEAT_VALID && !(TX_USR_VALID && TX_USR_READY) |=> !TX_BEAT_VALID)
		else $error("beat offered without a source");
	AST_TX_FIELDS: assert property (TX_USR_VALID && TX_USR_READY && (!TX_BEAT_VALID || TX_BEAT_ACCEPT)
		|=> {TX_FLOW_ID, TX_PAYLOAD, TX_BYTE_STROBE, TX_BYTE_KEEP, TX_PACKET_END} == $past(TX_USR_BEAT))
		else $error("transmit fields differ from taken beat");
	AST_RXU_HOLD: assert property (rx_usr_stall |=> RX_USR_VALID && $stable(RX_USR_BEAT))
		else $error("received beat changed while stalled");
	AST_RX_NULL: assert property (RX_USR_VALID |-> RX_USR_BEAT.byte_count <= 4'h8
		&& (RX_USR_BEAT.byte_count != 4'h0 || RX_USR_BEAT.packet_end)) else $error("empty beat shown");
	AST_RX_TOP: assert property (RX_USR_VALID |->
		(RX_USR_BEAT.payload >> {RX_USR_BEAT.byte_count, 3'h0}) == 64'h0) else $error("bytes above count not zero");
endmodule : csp_stream_port_properties

bind csp_stream_port csp_stream_port_properties u_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.TX_USR_VALID(TX_USR_VALID), .TX_USR_READY(TX_USR_READY), .TX_USR_BEAT(TX_USR_BEAT),
	.TX_BEAT_ACCEPT(TX_BEAT_ACCEPT), .TX_BEAT_VALID(TX_BEAT_VALID), .TX_ROUTE_DEST(TX_ROUTE_DEST),
	.TX_FLOW_ID(TX_FLOW_ID), .TX_PAYLOAD(TX_PAYLOAD), .TX_BYTE_STROBE(TX_BYTE_STROBE),
	.TX_BYTE_KEEP(TX_BYTE_KEEP), .TX_PACKET_END(TX_PACKET_END), .RX_USR_VALID(RX_USR_VALID),
	.RX_USR_READY(RX_USR_READY), .RX_USR_BEAT(RX_USR_BEAT));

// ==== verif/csp_peer_model.sv ====
// Peer chip's stream port: slave for our transmit, master for our receive
`timescale 1ns/1ps
module csp_peer_model (
	// Clock and pacing (0 prompt, 1 every other cycle, 2 detached: ready and idle receive lines low)
	input  wire logic                 CLOCK,
	input  wire logic [1:0]           stall_mode,
	// Our transmit direction
	input  wire logic                 TX_BEAT_VALID,
	input  wire csp_pkg::csp_tx_beat_t tx_beat,
	output      logic                 TX_BEAT_ACCEPT,
	// Our receive direction
	output      logic                 RX_BEAT_VALID,
	output      csp_pkg::csp_rx_beat_t rx_beat,
	input  wire logic                 RX_BEAT_ACCEPT
);
	csp_pkg::csp_tx_beat_t tx_got[$];
	csp_pkg::csp_rx_beat_t rx_send[$];
	logic                  tog = 1'b0;

	initial begin
		TX_BEAT_ACCEPT = 1'b0;
		RX_BEAT_VALID = 1'b0;
		rx_beat = '0;
	end

	// Slot frees only on a taken beat, so an offer never changes early
	always @(posedge CLOCK) begin
		tog <= ~tog;
		if (TX_BEAT_VALID && TX_BEAT_ACCEPT) tx_got.push_back(tx_beat);
		TX_BEAT_ACCEPT <= (stall_mode == 2'h0) || (stall_mode == 2'h1 && tog);
		if (RX_BEAT_VALID && RX_BEAT_ACCEPT) void'(rx_send.pop_front());
		if (!RX_BEAT_VALID || RX_BEAT_ACCEPT) begin
			if (rx_send.size() > 0 && !(stall_mode == 2'h1 && tog)) begin
				RX_BEAT_VALID <= 1'b1;
				rx_beat <= rx_send[0];
			end else begin
				// Idle lines toggle so stale data never looks valid; a detached master ties them low
				RX_BEAT_VALID <= 1'b0;
				rx_beat <= (stall_mode == 2'h2) ? '0 : ~rx_beat;
			end
		end
	end
endmodule : csp_peer_model

// ==== verif/csp_stream_port_bench.sv ====
// Self-checking bench for the chip-to-chip stream port
`timescale 1ns/1ps
module csp_stream_port_bench;
	logic CLOCK = 1'b0, SYS_RST = 1'b1, TX_USR_VALID = 1'b0, RX_USR_READY = 1'b0;
	logic [1:0] stall_mode = 2'h0;
	csp_pkg::csp_tx_beat_t TX_USR_BEAT = '0;
	csp_pkg::csp_rx_out_t  RX_USR_BEAT;
	csp_pkg::csp_rx_beat_t rxb;
	csp_pkg::csp_rx_out_t  got[$];
	logic TX_USR_READY, TX_BEAT_ACCEPT, TX_BEAT_VALID, TX_PACKET_END, RX_BEAT_ACCEPT, RX_BEAT_VALID, RX_USR_VALID;
	logic [7:0] TX_ROUTE_DEST, TX_FLOW_ID, TX_BYTE_STROBE, TX_BYTE_KEEP;
	logic [63:0] TX_PAYLOAD;
	int err_total = 0, compares = 0;

	always #25 CLOCK = ~CLOCK;

	csp_stream_port #(.RX_FIFO_DEPTH(16)) uut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .TX_USR_VALID(TX_USR_VALID),
		.TX_USR_READY(TX_USR_READY), .TX_USR_BEAT(TX_USR_BEAT), .TX_BEAT_ACCEPT(TX_BEAT_ACCEPT),
		.TX_BEAT_VALID(TX_BEAT_VALID), .TX_ROUTE_DEST(TX_ROUTE_DEST), .TX_FLOW_ID(TX_FLOW_ID),
		.TX_PAYLOAD(TX_PAYLOAD), .TX_BYTE_STROBE(TX_BYTE_STROBE), .TX_BYTE_KEEP(TX_BYTE_KEEP),
		.TX_PACKET_END(TX_PACKET_END), .RX_BEAT_ACCEPT(RX_BEAT_ACCEPT), .RX_BEAT_VALID(RX_BEAT_VALID),
		.RX_ROUTE_DEST(rxb.route_dest), .RX_FLOW_ID(rxb.flow_id), .RX_REMOTE_AGENT_ROUTE(rxb.remote_agent_route),
		.RX_PAYLOAD(rxb.payload), .RX_BYTE_STROBE(rxb.byte_strobe), .RX_BYTE_KEEP(rxb.byte_keep),
		.RX_PACKET_END(rxb.packet_end), .RX_USR_VALID(RX_USR_VALID), .RX_USR_READY(RX_USR_READY),
		.RX_USR_BEAT(RX_USR_BEAT));
	csp_peer_model peer (.CLOCK(CLOCK), .stall_mode(stall_mode), .TX_BEAT_VALID(TX_BEAT_VALID),
		.tx_beat({TX_FLOW_ID, TX_PAYLOAD, TX_BYTE_STROBE, TX_BYTE_KEEP, TX_PACKET_END}),
		.TX_BEAT_ACCEPT(TX_BEAT_ACCEPT), .RX_BEAT_VALID(RX_BEAT_VALID), .rx_beat(rxb),
		.RX_BEAT_ACCEPT(RX_BEAT_ACCEPT));

	task automatic give_verdict;
		$display("Counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic hang(input int n);
		if (n > 400) begin
			err_total++;
			$display("ERROR %0t: wait ran out", $time);
			give_verdict();
		end
	endtask : hang

	// Offer one beat; valid stays up for a following call
	task automatic put_tx(input csp_pkg::csp_tx_beat_t b);
		int n;
		n = 0;
		TX_USR_VALID <= 1'b1;
		TX_USR_BEAT <= b;
		@(negedge CLOCK);
		while (!TX_USR_READY) begin
			hang(++n);
			@(negedge CLOCK);
		end
		@(posedge CLOCK);
	endtask : put_tx

	// Gather user-side receive beats until n are held
	task automatic collect(input int n);
		int k;
		k = 0;
		while (got.size() < n) begin
			hang(++k);
			@(negedge CLOCK);
			if (RX_USR_VALID && RX_USR_READY) got.push_back(RX_USR_BEAT);
			@(posedge CLOCK);
		end
	endtask : collect

	// Reference null-byte removal, kept bytes packed low
	function automatic csp_pkg::csp_rx_out_t squeeze(input csp_pkg::csp_rx_beat_t b);
		csp_pkg::csp_rx_out_t o;
		int k;
		o = '0;
		k = 0;
		{o.route_dest, o.flow_id, o.remote_agent_route} = {b.route_dest, b.flow_id, b.remote_agent_route};
		o.packet_end = b.packet_end;
		for (int i = 0; i < 8; i++) if (b.byte_keep[i]) begin
			o.payload[8*k +: 8] = b.payload[8*i +: 8];
			o.byte_strobe[k] = b.byte_strobe[i];
			k++;
		end
		o.byte_count = 4'(k);
		return o;
	endfunction : squeeze

	function automatic csp_pkg::csp_tx_beat_t tx_pat(input int i);
		return {8'(8'h10 + i), 64'h0123456789abcdef ^ {8{8'(i)}}, 8'(8'h0f << i), 8'(8'hf0 >> i), i == 3};
	endfunction : tx_pat

	// Ready tied low first (second beat parks in the skid), then a stalling peer drains four beats in order
	task automatic test_tx;
		int n;
		n = 0;
		stall_mode <= 2'h2;
		for (int i = 0; i < 2; i++) put_tx(tx_pat(i));
		TX_USR_VALID <= 1'b0;
		repeat (10) @(posedge CLOCK);
		check(peer.tx_got.size(), 0);
		check(TX_BEAT_VALID, 1'b1);
		check(TX_USR_READY, 1'b0);
		check(TX_ROUTE_DEST, 8'h00);
		check(RX_USR_VALID, 1'b0);
		stall_mode <= 2'h1;
		for (int i = 2; i < 4; i++) put_tx(tx_pat(i));
		TX_USR_VALID <= 1'b0;
		while (peer.tx_got.size() < 4) begin
			hang(++n);
			@(posedge CLOCK);
		end
		for (int i = 0; i < 4; i++) check(peer.tx_got[i], tx_pat(i));
		$display("test_tx done");
	endtask : test_tx

	// Sparse, full, dropped and end-only keep patterns
	task automatic test_rx_squeeze;
		csp_pkg::csp_rx_beat_t b[4];
		b[0] = {8'h11, 8'h21, 8'h31, 64'h8877665544332211, 8'h5a, 8'ha1, 1'b0};
		b[1] = {8'h12, 8'h22, 8'h32, 64'hfedcba9876543210, 8'hff, 8'hff, 1'b1};
		b[2] = {8'h13, 8'h23, 8'h33, 64'h1111111111111111, 8'hff, 8'h00, 1'b0};
		b[3] = {8'h14, 8'h24, 8'h34, 64'h2222222222222222, 8'h0f, 8'h00, 1'b1};
		got.delete();
		stall_mode <= 2'h1;
		RX_USR_READY <= 1'b1;
		foreach (b[i]) peer.rx_send.push_back(b[i]);
		collect(3);
		check(got[0], squeeze(b[0]));
		check(got[1], squeeze(b[1]));
		check(got[2], squeeze(b[3]));
		$display("test_rx_squeeze done");
	endtask : test_rx_squeeze

	// Mesh side stalls until the port refuses, then drains all in order
	task automatic test_rx_fill;
		int n;
		n = 0;
		got.delete();
		stall_mode <= 2'h0;
		RX_USR_READY <= 1'b0;
		for (int i = 0; i < 20; i++) peer.rx_send.push_back({24'h0, 64'(i), 8'hff, 8'hff, 1'b0});
		@(negedge CLOCK);
		while (RX_BEAT_ACCEPT) begin
			hang(++n);
			@(negedge CLOCK);
		end
		repeat (4) @(posedge CLOCK);
		check(peer.rx_send.size() > 0, 1'b1);
		check(RX_BEAT_ACCEPT, 1'b0);
		RX_USR_READY <= 1'b1;
		collect(20);
		for (int i = 0; i < 20; i++) check(got[i].payload, 64'(i));
		$display("test_rx_fill done");
	endtask : test_rx_fill

	initial begin
		repeat (5) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CLOCK);
		test_tx();
		test_rx_squeeze();
		test_rx_fill();
		give_verdict();
	end
endmodule : csp_stream_port_bench
